// ==== hdl/cte_pkg.sv ====
// Constants, encodings and types for the transfer and arithmetic executor
package cte_pkg;

  // ----------------------------------------------------------------
  // Register and pair codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_B   = 3'h0;
  localparam logic [2:0] REG_D   = 3'h2;
  localparam logic [2:0] REG_E   = 3'h3;
  localparam logic [2:0] REG_H   = 3'h4;
  localparam logic [2:0] REG_L   = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A   = 3'h7;
  localparam logic [1:0] PAIR_SP = 2'h3;

  // ----------------------------------------------------------------
  // Flag positions and reset values
  // ----------------------------------------------------------------
  localparam int         FL_CY     = 0;
  localparam int         FL_P      = 1;
  localparam int         FL_AC     = 2;
  localparam int         FL_Z      = 3;
  localparam int         FL_S      = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [15:0] SP_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Opcodes decoded whole
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_HALT_SLOT = 8'h76;
  localparam logic [7:0] OP_ACC_DLD   = 8'h3A;
  localparam logic [7:0] OP_ACC_DST   = 8'h32;
  localparam logic [7:0] OP_HL_DLD    = 8'h2A;
  localparam logic [7:0] OP_HL_DST    = 8'h22;
  localparam logic [7:0] OP_SWAP      = 8'hEB;
  localparam logic [7:0] OP_IMM_SUM   = 8'hC6;
  localparam logic [7:0] OP_IMM_SUMC  = 8'hCE;

  // ----------------------------------------------------------------
  // Timing in states
  // ----------------------------------------------------------------
  localparam logic [4:0] STATES_REG  = 5'h04;
  localparam logic [4:0] STATES_COPY = 5'h05;
  localparam logic [4:0] STATES_2CYC = 5'h07;
  localparam logic [4:0] STATES_3CYC = 5'h0A;
  localparam logic [4:0] STATES_4CYC = 5'h0D;
  localparam logic [4:0] STATES_5CYC = 5'h10;

  typedef enum logic [2:0] {
    TS_T1 = 3'b000,
    TS_T2 = 3'b001,
    TS_T3 = 3'b010,
    TS_T4 = 3'b011,
    TS_T5 = 3'b100
  } cte_tstate_t;

  typedef enum logic [4:0] {
    K_NONE     = 5'b00000,
    K_COPY_RR  = 5'b00001,
    K_COPY_RM  = 5'b00010,
    K_COPY_MR  = 5'b00011,
    K_IMM_R    = 5'b00100,
    K_IMM_M    = 5'b00101,
    K_PAIR_IMM = 5'b00110,
    K_ACC_DLD  = 5'b00111,
    K_ACC_DST  = 5'b01000,
    K_HL_DLD   = 5'b01001,
    K_HL_DST   = 5'b01010,
    K_ACC_ILD  = 5'b01011,
    K_ACC_IST  = 5'b01100,
    K_SWAP     = 5'b01101,
    K_ALU_R    = 5'b01110,
    K_ALU_M    = 5'b01111,
    K_ALU_I    = 5'b10000
  } cte_kind_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'b00,
    ALU_ADC = 2'b01,
    ALU_SUB = 2'b10
  } cte_alu_op_t;

endpackage : cte_pkg

// ==== hdl/cte_alu.sv ====
// Eight-bit adder and subtractor with the five condition flags
`timescale 1ns/1ns
module cte_alu (
  input  wire logic [7:0]           a_in,
  input  wire logic [7:0]           b_in,
  input  wire logic                 cy_in,
  input  wire cte_pkg::cte_alu_op_t op_in,
  output logic      [7:0]           res_out,
  output logic      [4:0]           flags_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bx;
  logic       cin;

  always_comb begin
    bx = (op_in == cte_pkg::ALU_SUB) ? ~b_in : b_in;
    cin = (op_in == cte_pkg::ALU_SUB) ? 1'b1 :
          ((op_in == cte_pkg::ALU_ADC) ? cy_in : 1'b0);
    sum = {1'b0, a_in} + {1'b0, bx} + {8'h00, cin};
    nib = {1'b0, a_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    res_out = sum[7:0];
    flags_out = cte_pkg::FLAGS_RST;
    // Borrow is the inverse of the two's complement carry
    flags_out[cte_pkg::FL_CY] = (op_in == cte_pkg::ALU_SUB) ? ~sum[8] : sum[8];
    flags_out[cte_pkg::FL_AC] = nib[4];
    flags_out[cte_pkg::FL_Z]  = (sum[7:0] == 8'h00);
    flags_out[cte_pkg::FL_S]  = sum[7];
    flags_out[cte_pkg::FL_P]  = ~(^sum[7:0]);
  end

endmodule : cte_alu

// ==== hdl/cte_core.sv ====
// Instruction decode and execute core for transfer and add/subtract groups
`timescale 1ns/1ns
module cte_core (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [15:0] mem_addr_out,
  output logic      [7:0]  mem_wdata_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic             instr_start_out,
  output logic             bad_opcode_out,
  output logic      [15:0] pc_out,
  output logic      [15:0] sp_out,
  output logic      [7:0]  acc_out,
  output logic      [15:0] bc_out,
  output logic      [15:0] de_out,
  output logic      [15:0] hl_out,
  output logic      [4:0]  flags_out,
  output logic      [15:0] restart_vec_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic cte_pkg::cte_kind_t decode_kind(input logic [7:0] op);
    decode_kind = cte_pkg::K_NONE;
    if (op[7:6] == 2'b01) begin
      if (op == cte_pkg::OP_HALT_SLOT) decode_kind = cte_pkg::K_NONE;
      else if (op[2:0] == cte_pkg::REG_MEM) decode_kind = cte_pkg::K_COPY_RM;
      else if (op[5:3] == cte_pkg::REG_MEM) decode_kind = cte_pkg::K_COPY_MR;
      else decode_kind = cte_pkg::K_COPY_RR;
    end else if (op[7:6] == 2'b00) begin
      if (op[2:0] == 3'h6) begin
        decode_kind = (op[5:3] == cte_pkg::REG_MEM) ? cte_pkg::K_IMM_M : cte_pkg::K_IMM_R;
      end else if (op[3:0] == 4'h1) decode_kind = cte_pkg::K_PAIR_IMM;
      else if (op == cte_pkg::OP_ACC_DLD) decode_kind = cte_pkg::K_ACC_DLD;
      else if (op == cte_pkg::OP_ACC_DST) decode_kind = cte_pkg::K_ACC_DST;
      else if (op == cte_pkg::OP_HL_DLD) decode_kind = cte_pkg::K_HL_DLD;
      else if (op == cte_pkg::OP_HL_DST) decode_kind = cte_pkg::K_HL_DST;
      else if (!op[5] && op[2:0] == 3'h2) begin
        // Only BC and DE codes exist here; other pairs are other opcodes
        decode_kind = op[3] ? cte_pkg::K_ACC_ILD : cte_pkg::K_ACC_IST;
      end
    end else if (op[7:6] == 2'b10) begin
      if (!op[5] && !(op[4] && op[3])) begin
        decode_kind = (op[2:0] == cte_pkg::REG_MEM) ? cte_pkg::K_ALU_M : cte_pkg::K_ALU_R;
      end
    end else begin
      if (op == cte_pkg::OP_IMM_SUM || op == cte_pkg::OP_IMM_SUMC)
        decode_kind = cte_pkg::K_ALU_I;
      else if (op == cte_pkg::OP_SWAP) decode_kind = cte_pkg::K_SWAP;
    end
  endfunction : decode_kind

  function automatic logic [2:0] n_cycles(input cte_pkg::cte_kind_t k);
    unique case (k)
      cte_pkg::K_IMM_M, cte_pkg::K_PAIR_IMM:   n_cycles = 3'h3;
      cte_pkg::K_ACC_DLD, cte_pkg::K_ACC_DST:  n_cycles = 3'h4;
      cte_pkg::K_HL_DLD, cte_pkg::K_HL_DST:    n_cycles = 3'h5;
      cte_pkg::K_NONE, cte_pkg::K_COPY_RR,
      cte_pkg::K_SWAP, cte_pkg::K_ALU_R:       n_cycles = 3'h1;
      default:                                 n_cycles = 3'h2;
    endcase
  endfunction : n_cycles

  cte_pkg::cte_tstate_t st_q;
  cte_pkg::cte_kind_t   kind;
  logic [2:0]  mcyc_q;
  logic [7:0]  ir_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [7:0]  rf_q [0:7];
  logic [4:0]  flags_q;
  logic [7:0]  lo_q;
  logic [7:0]  hi_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic        wr_q;
  logic        frompc_q;
  logic [15:0] restart_q;
  logic [2:0]  dst;
  logic [2:0]  src;
  logic [1:0]  pair;
  logic        m1_last;
  logic        cyc_last;
  logic        rd_done;
  logic [2:0]  mcyc_inc;

  assign kind = decode_kind(ir_q);
  assign dst  = ir_q[5:3];
  assign src  = ir_q[2:0];
  assign pair = ir_q[5:4];

  // Contents of a pair, first register high
  function automatic logic [15:0] pair_word(input logic [1:0] p);
    if (p == cte_pkg::PAIR_SP) pair_word = sp_q;
    else pair_word = {rf_q[{p, 1'b0}], rf_q[{p, 1'b1}]};
  endfunction : pair_word

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Register copy stretches the opcode cycle to five states
  assign m1_last = (mcyc_q == 3'h0) && ((st_q == cte_pkg::TS_T4 &&
                   kind != cte_pkg::K_COPY_RR) || st_q == cte_pkg::TS_T5);
  assign cyc_last = m1_last || (mcyc_q != 3'h0 && st_q == cte_pkg::TS_T3);
  assign rd_done  = (mcyc_q != 3'h0) && (st_q == cte_pkg::TS_T3) && !wr_q;
  assign mcyc_inc = mcyc_q + 3'h1;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= cte_pkg::TS_T1;
    end else begin
      unique case (st_q)
        cte_pkg::TS_T1: st_q <= cte_pkg::TS_T2;
        cte_pkg::TS_T2: st_q <= cte_pkg::TS_T3;
        cte_pkg::TS_T3: st_q <= (mcyc_q == 3'h0) ? cte_pkg::TS_T4 : cte_pkg::TS_T1;
        cte_pkg::TS_T4: st_q <= m1_last ? cte_pkg::TS_T1 : cte_pkg::TS_T5;
        cte_pkg::TS_T5: st_q <= cte_pkg::TS_T1;
        default:        st_q <= cte_pkg::TS_T1;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mcyc_q <= 3'h0;
    end else if (cyc_last) begin
      mcyc_q <= (mcyc_inc == n_cycles(kind)) ? 3'h0 : mcyc_inc;
    end
  end

  // ----------------------------------------------------------------
  // Memory cycle address, direction and data
  // ----------------------------------------------------------------
  logic [15:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        cyc_wr;
  logic        cyc_pc;
  logic [15:0] dir_addr;

  assign dir_addr = {hi_q, lo_q};

  always_comb begin
    cyc_addr  = pc_q;
    cyc_wdata = cte_pkg::REG_RST;
    cyc_wr    = 1'b0;
    cyc_pc    = 1'b1;
    if (mcyc_q != 3'h0) begin
      unique case (kind)
        cte_pkg::K_COPY_RM, cte_pkg::K_ALU_M: begin
          cyc_addr = pair_word(2'h2);
          cyc_pc   = 1'b0;
        end
        cte_pkg::K_COPY_MR: begin
          cyc_addr  = pair_word(2'h2);
          cyc_pc    = 1'b0;
          cyc_wr    = 1'b1;
          cyc_wdata = rf_q[src];
        end
        cte_pkg::K_IMM_M: begin
          if (mcyc_q == 3'h2) begin
            cyc_addr  = pair_word(2'h2);
            cyc_pc    = 1'b0;
            cyc_wr    = 1'b1;
            cyc_wdata = lo_q;
          end
        end
        cte_pkg::K_ACC_DLD, cte_pkg::K_ACC_DST: begin
          if (mcyc_q == 3'h3) begin
            cyc_addr  = dir_addr;
            cyc_pc    = 1'b0;
            cyc_wr    = (kind == cte_pkg::K_ACC_DST);
            cyc_wdata = rf_q[cte_pkg::REG_A];
          end
        end
        cte_pkg::K_HL_DLD, cte_pkg::K_HL_DST: begin
          if (mcyc_q >= 3'h3) begin
            // L goes at the direct address, H at the one after
            cyc_addr  = (mcyc_q == 3'h3) ? dir_addr : dir_addr + 16'h0001;
            cyc_pc    = 1'b0;
            cyc_wr    = (kind == cte_pkg::K_HL_DST);
            cyc_wdata = (mcyc_q == 3'h3) ? rf_q[cte_pkg::REG_L] : rf_q[cte_pkg::REG_H];
          end
        end
        cte_pkg::K_ACC_ILD, cte_pkg::K_ACC_IST: begin
          cyc_addr  = pair_word(pair);
          cyc_pc    = 1'b0;
          cyc_wr    = (kind == cte_pkg::K_ACC_IST);
          cyc_wdata = rf_q[cte_pkg::REG_A];
        end
        default: begin
          cyc_addr = pc_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q   <= cte_pkg::PC_RST;
      wdata_q  <= cte_pkg::REG_RST;
      wr_q     <= 1'b0;
      frompc_q <= 1'b0;
    end else if (st_q == cte_pkg::TS_T1) begin
      addr_q   <= cyc_addr;
      wdata_q  <= cyc_wdata;
      wr_q     <= cyc_wr;
      frompc_q <= cyc_pc;
    end
  end

  assign mem_addr_out    = addr_q;
  assign mem_wdata_out   = wdata_q;
  assign mem_rd_out      = (st_q == cte_pkg::TS_T2 || st_q == cte_pkg::TS_T3) && !wr_q;
  assign mem_wr_out      = (st_q == cte_pkg::TS_T2) && wr_q;
  assign instr_start_out = (st_q == cte_pkg::TS_T1) && (mcyc_q == 3'h0);
  assign bad_opcode_out  = (st_q == cte_pkg::TS_T4) && (mcyc_q == 3'h0) &&
                           (kind == cte_pkg::K_NONE);

  // ----------------------------------------------------------------
  // Opcode, operand bytes and program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_q <= cte_pkg::REG_RST;
      lo_q <= cte_pkg::REG_RST;
      hi_q <= cte_pkg::REG_RST;
    end else if (mcyc_q == 3'h0 && st_q == cte_pkg::TS_T3) begin
      ir_q <= mem_rdata_in;
    end else if (rd_done && frompc_q) begin
      if (mcyc_q == 3'h1) lo_q <= mem_rdata_in;
      else hi_q <= mem_rdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_q <= cte_pkg::PC_RST;
    end else if ((mcyc_q == 3'h0 && st_q == cte_pkg::TS_T3) || (rd_done && frompc_q)) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_q <= cte_pkg::SP_RST;
    end else if (rd_done && kind == cte_pkg::K_PAIR_IMM && mcyc_q == 3'h2 &&
                 pair == cte_pkg::PAIR_SP) begin
      sp_q[15:8] <= mem_rdata_in;
      sp_q[7:0]  <= lo_q;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  cte_pkg::cte_alu_op_t alu_op;
  logic [7:0] alu_res;
  logic [4:0] alu_flags;
  logic       alu_exec;

  always_comb begin
    if (kind == cte_pkg::K_ALU_I) alu_op = ir_q[3] ? cte_pkg::ALU_ADC : cte_pkg::ALU_ADD;
    else if (ir_q[4]) alu_op = cte_pkg::ALU_SUB;
    else alu_op = ir_q[3] ? cte_pkg::ALU_ADC : cte_pkg::ALU_ADD;
  end

  cte_alu u_alu (
    .a_in      (rf_q[cte_pkg::REG_A]),
    .b_in      ((kind == cte_pkg::K_ALU_R) ? rf_q[src] : mem_rdata_in),
    .cy_in     (flags_q[cte_pkg::FL_CY]),
    .op_in     (alu_op),
    .res_out   (alu_res),
    .flags_out (alu_flags)
  );

  assign alu_exec = (m1_last && kind == cte_pkg::K_ALU_R) ||
                    (rd_done && (kind == cte_pkg::K_ALU_M || kind == cte_pkg::K_ALU_I));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= cte_pkg::FLAGS_RST;
    end else if (alu_exec) begin
      flags_q <= alu_flags;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 8; i++) rf_q[i] <= cte_pkg::REG_RST;
    end else if (alu_exec) begin
      rf_q[cte_pkg::REG_A] <= alu_res;
    end else if (m1_last && kind == cte_pkg::K_COPY_RR) begin
      rf_q[dst] <= rf_q[src];
    end else if (m1_last && kind == cte_pkg::K_SWAP) begin
      rf_q[cte_pkg::REG_H] <= rf_q[cte_pkg::REG_D];
      rf_q[cte_pkg::REG_D] <= rf_q[cte_pkg::REG_H];
      rf_q[cte_pkg::REG_L] <= rf_q[cte_pkg::REG_E];
      rf_q[cte_pkg::REG_E] <= rf_q[cte_pkg::REG_L];
    end else if (rd_done) begin
      unique case (kind)
        cte_pkg::K_COPY_RM: rf_q[dst] <= mem_rdata_in;
        cte_pkg::K_IMM_R:   rf_q[dst] <= mem_rdata_in;
        cte_pkg::K_PAIR_IMM: begin
          if (mcyc_q == 3'h2 && pair != cte_pkg::PAIR_SP) begin
            rf_q[{pair, 1'b0}] <= mem_rdata_in;
            rf_q[{pair, 1'b1}] <= lo_q;
          end
        end
        cte_pkg::K_ACC_DLD: if (mcyc_q == 3'h3) rf_q[cte_pkg::REG_A] <= mem_rdata_in;
        cte_pkg::K_ACC_ILD: rf_q[cte_pkg::REG_A] <= mem_rdata_in;
        cte_pkg::K_HL_DLD: begin
          if (mcyc_q == 3'h3) rf_q[cte_pkg::REG_L] <= mem_rdata_in;
          else if (mcyc_q == 3'h4) rf_q[cte_pkg::REG_H] <= mem_rdata_in;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      restart_q <= cte_pkg::PC_RST;
    end else if (st_q == cte_pkg::TS_T4 && mcyc_q == 3'h0 && ir_q[7:6] == 2'b11 &&
                 ir_q[2:0] == 3'h7) begin
      restart_q <= {10'h000, ir_q[5:3], 3'h0};
    end
  end

  assign pc_out          = pc_q;
  assign sp_out          = sp_q;
  assign acc_out         = rf_q[cte_pkg::REG_A];
  assign bc_out          = pair_word(2'h0);
  assign de_out          = pair_word(2'h1);
  assign hl_out          = pair_word(2'h2);
  assign flags_out       = flags_q;
  assign restart_vec_out = restart_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [4:0] len_q;
  logic       started_q;
  logic [4:0] fl_start_q;
  logic       seen;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      len_q      <= 5'h00;
      started_q  <= 1'b0;
      fl_start_q <= cte_pkg::FLAGS_RST;
    end else begin
      len_q      <= instr_start_out ? 5'h01 : len_q + 5'h01;
      started_q  <= started_q | instr_start_out;
      fl_start_q <= instr_start_out ? flags_q : fl_start_q;
    end
  end

  assign seen = instr_start_out && started_q;

  sequence s_read_cycle;
    mem_rd_out ##1 mem_rd_out ##1 !mem_rd_out;
  endsequence

  a_copy_len: assert property (seen && kind == cte_pkg::K_COPY_RR |->
    len_q == cte_pkg::STATES_COPY) else $error("register copy length wrong");
  a_mem_len: assert property (seen && (kind == cte_pkg::K_COPY_RM ||
    kind == cte_pkg::K_COPY_MR || kind == cte_pkg::K_IMM_R) |->
    len_q == cte_pkg::STATES_2CYC) else $error("memory copy length wrong");
  a_store_len: assert property (seen && (kind == cte_pkg::K_IMM_M ||
    kind == cte_pkg::K_PAIR_IMM) |-> len_q == cte_pkg::STATES_3CYC)
    else $error("three cycle length wrong");
  a_direct_len: assert property (seen && (kind == cte_pkg::K_ACC_DLD ||
    kind == cte_pkg::K_ACC_DST) |-> len_q == cte_pkg::STATES_4CYC)
    else $error("direct access length wrong");
  a_hl_len: assert property (seen && (kind == cte_pkg::K_HL_DLD ||
    kind == cte_pkg::K_HL_DST) |-> len_q == cte_pkg::STATES_5CYC)
    else $error("direct pair length wrong");
  a_short_len: assert property (seen && (kind == cte_pkg::K_SWAP ||
    kind == cte_pkg::K_ALU_R) |-> len_q == cte_pkg::STATES_REG)
    else $error("register operation length wrong");
  a_flags_kept: assert property (seen && kind != cte_pkg::K_NONE &&
    kind != cte_pkg::K_ALU_R && kind != cte_pkg::K_ALU_M && kind != cte_pkg::K_ALU_I
    |-> flags_q == fl_start_q) else $error("transfer changed flags");
  a_swap_pairs: assert property (m1_last && kind == cte_pkg::K_SWAP |=>
    hl_out == $past(de_out) && de_out == $past(hl_out) && flags_q == $past(flags_q))
    else $error("swap result wrong");
  a_hl_read: assert property (st_q == cte_pkg::TS_T1 && mcyc_q != 3'h0 &&
    kind == cte_pkg::K_COPY_RM |=> mem_addr_out == hl_out ##0 s_read_cycle)
    else $error("memory copy not read through HL");

endmodule : cte_core

// ==== verif/cte_mem_model.sv ====
// Zero-wait byte memory that answers the core's bus
`timescale 1ns/1ns
module cte_mem_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // Released bus shows the inverted last byte, so stale data never passes for valid
  assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    if (rd_in) last_q <= mem[addr_in];
    if (wr_in) mem[addr_in] <= wdata_in;
  end
endmodule : cte_mem_model

// ==== verif/cte_core_tb_top.sv ====
// Self-checking bench running a short program through the core
`timescale 1ns/1ns
`define CHK(nm, ex, got) cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end
module cte_core_tb_top;
  logic        clk_in;
  logic        rst_n_in;
  logic [7:0]  rdata;
  logic [15:0] addr, pc, sp, bc, de, hl, rvec;
  logic [7:0]  wdata, acc;
  logic        rd, wr, start, bad;
  logic [4:0]  flags;
  int          errors = 0;
  int          cmp_count = 0;
  int          bad_cnt = 0;
  logic [7:0]  prog[$] = '{8'h21, 8'h34, 8'h12, 8'h11, 8'hCD, 8'hAB, 8'h3E, 8'h8F, 8'h06,
    8'h71, 8'h4F, 8'h80, 8'h89, 8'h91, 8'h90, 8'h70, 8'h7E, 8'h32, 8'h00, 8'h20, 8'h22,
    8'h00, 8'h30, 8'hEB, 8'h2A, 8'h00, 8'h30, 8'h0A, 8'hC6, 8'hA6, 8'h36, 8'hC3,
    8'hCE, 8'h10, 8'h86, 8'h96, 8'h02, 8'h31, 8'h78, 8'h56, 8'hEF};

  cte_core dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .mem_rdata_in(rdata),
    .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(rd), .mem_wr_out(wr),
    .instr_start_out(start), .bad_opcode_out(bad), .pc_out(pc), .sp_out(sp),
    .acc_out(acc), .bc_out(bc), .de_out(de), .hl_out(hl), .flags_out(flags),
    .restart_vec_out(rvec));
  cte_mem_model mem_u (.clk_in(clk_in), .addr_in(addr), .wdata_in(wdata), .rd_in(rd),
    .wr_in(wr), .rdata_out(rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // Counts states from one fetch start to the next
  task automatic step(input int ex, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (start !== 1'b1 && n < 40);
    `CHK(nm, ex, n)
  endtask : step

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_loads();
    step(10, "pair_load_hl");
    `CHK("hl", 16'h1234, hl)
    step(10, "pair_load_de");
    `CHK("de", 16'hABCD, de)
    step(7, "imm_a");
    `CHK("acc", 8'h8F, acc)
    step(7, "imm_b");
    step(5, "copy_c_a");
    `CHK("bc", 16'h718F, bc)
    `CHK("flags", 5'h00, flags)
  endtask : t_loads

  task automatic t_arith();
    step(4, "add_b");
    `CHK("add acc", 8'h00, acc)
    `CHK("add flags", 5'h0F, flags)
    step(4, "adc_c");
    `CHK("adc acc", 8'h90, acc)
    `CHK("adc flags", 5'h16, flags)
    step(4, "sub_c");
    `CHK("sub acc", 8'h01, acc)
    step(4, "sub_b");
    `CHK("sub acc2", 8'h90, acc)
    `CHK("sub flags", 5'h17, flags)
  endtask : t_arith

  task automatic t_memory();
    step(7, "copy_to_mem");
    `CHK("mem1234", 8'h71, mem_u.mem[16'h1234])
    step(7, "copy_from_mem");
    `CHK("acc", 8'h71, acc)
    `CHK("flags kept", 5'h17, flags)
    step(13, "acc_store");
    `CHK("mem2000", 8'h71, mem_u.mem[16'h2000])
    step(16, "hl_store");
    `CHK("mem3000", 8'h34, mem_u.mem[16'h3000])
    `CHK("mem3001", 8'h12, mem_u.mem[16'h3001])
  endtask : t_memory

  task automatic t_swap_ind();
    step(4, "swap");
    `CHK("hl swap", 16'hABCD, hl)
    `CHK("de swap", 16'h1234, de)
    step(16, "hl_load");
    `CHK("hl load", 16'h1234, hl)
    step(7, "acc_ind_load");
    `CHK("acc ind", 8'h5A, acc)
    step(7, "imm_sum");
    `CHK("imm acc", 8'h00, acc)
    `CHK("imm flags", 5'h0F, flags)
    step(10, "imm_mem");
    `CHK("mem imm", 8'hC3, mem_u.mem[16'h1234])
    `CHK("pc", 16'h0020, pc)
    `CHK("sp", 16'h0000, sp)
  endtask : t_swap_ind

  task automatic t_extra();
    step(7, "imm_sum_carry");
    `CHK("aci acc", 8'h11, acc)
    `CHK("aci flags", 5'h02, flags)
    step(7, "add_mem");
    `CHK("add m acc", 8'hD4, acc)
    `CHK("add m flags", 5'h12, flags)
    step(7, "sub_mem");
    `CHK("sub m acc", 8'h11, acc)
    `CHK("sub m flags", 5'h06, flags)
    step(7, "acc_ind_store");
    `CHK("mem718f", 8'h11, mem_u.mem[16'h718F])
    `CHK("flags st", 5'h06, flags)
    step(10, "pair_load_sp");
    `CHK("sp load", 16'h5678, sp)
    step(4, "restart_slot");
    `CHK("restart", 16'h0028, rvec)
    `CHK("bad count", 1, bad_cnt)
    `CHK("pc end", 16'h0029, pc)
  endtask : t_extra

  // Mid-run reset, then the first instruction must run cleanly again
  task automatic t_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    `CHK("pc rst", 16'h0000, pc)
    `CHK("sp rst", 16'h0000, sp)
    step(10, "pair_load_again");
    `CHK("hl again", 16'h1234, hl)
  endtask : t_reset

  // Unsupported opcode pulses, sampled away from the launching edge
  always @(negedge clk_in) if (bad === 1'b1) bad_cnt++;

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Whole program needs about 210 cycles
  initial begin
    repeat (3000) @(posedge clk_in);
    errors++;
    conclude();
  end

  initial begin
    rst_n_in = 1'b0;
    foreach (prog[i]) mem_u.mem[i] = prog[i];
    mem_u.mem[16'h718F] = 8'h5A;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    t_loads();
    t_arith();
    t_memory();
    t_swap_ind();
    t_extra();
    t_reset();
    conclude();
  end
endmodule : cte_core_tb_top
